// File: dv/floppy_drive_model.sv
// drive-side model: one floppy drive answering on the status lines
// assumes pin levels from the controller and the polarity setting from the bench
`timescale 1ns/1ps
module floppy_drive_model
   import floppy_cfg_pkg::*;
(
   input wire logic i_pol,
   input wire drive_pins_s i_pins,
   input wire logic i_track_zero,
   input wire logic i_disk_change,
   input wire logic i_write_protect,
   output logic o_track_zero_n,
   output logic o_disk_change_n,
   output logic o_write_protect_n
);
   logic selected;
   // either select line active at the pin level
   assign selected = i_pol ? |i_pins.drive_sel : ~&i_pins.drive_sel;
   // a deselected drive lets its open-collector lines float up to the pull-up
   assign o_track_zero_n = selected ? (i_pol ~^ i_track_zero) : 1'h1;
   assign o_disk_change_n = selected ? (i_pol ~^ i_disk_change) : 1'h1;
   assign o_write_protect_n = selected ? (i_pol ~^ i_write_protect) : 1'h1;
endmodule

// File: dv/tb_floppy_ctrl_config_regs.sv
// self-checking bench for the floppy configuration registers
// assumes the design package, the design and the drive model are compiled first
`timescale 1ns/1ps
module tb_floppy_ctrl_config_regs;
   import floppy_cfg_pkg::*;
   logic i_sys_clk = 1'h0, i_resetn = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic [ADDR_W-1:0] i_paddr = '0;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic o_pready, o_pslverr, i_ctl_dma_request = 1'h0, i_ctl_dma_ack = 1'h0;
   logic [1:0] i_ctl_drive_sel = 2'h0, i_ctl_motor_on = 2'h0, i_ctl_drate = 2'h0;
   logic i_ctl_write_gate = 1'h0, i_ctl_write_data = 1'h0, st_tz = 1'h0, st_dc = 1'h0, st_wp = 1'h0;
   logic tz_n, dc_n, wp_n, o_input_pullup_en, o_track_zero, o_disk_change, o_write_protect;
   logic o_sra_second_drive, o_precomp_enable, o_enhanced_3mode;
   logic [1:0] o_tape_media_id, o_rate_table_sel, o_interface_mode, o_boot_drive;
   logic [7:0] o_per_drive_type, o_drive_one_config;
   logic [3:0] o_dma_request;
   logic [7:0] ifc = 8'h8e;
   drive_pins_s o_drive;
   int seed, fail_count = 0, check_count = 0;

   always #4 i_sys_clk = ~i_sys_clk;

   floppy_ctrl_config_regs floppy_ctrl_config_regs_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_ctl_dma_request(i_ctl_dma_request),
      .i_ctl_dma_ack(i_ctl_dma_ack), .i_ctl_drive_sel(i_ctl_drive_sel), .i_ctl_motor_on(i_ctl_motor_on),
      .i_ctl_write_gate(i_ctl_write_gate), .i_ctl_write_data(i_ctl_write_data), .i_ctl_drate(i_ctl_drate),
      .i_track_zero_in_n(tz_n), .i_disk_change_in_n(dc_n), .i_write_protect_in_n(wp_n),
      .o_dma_request(o_dma_request), .o_drive(o_drive), .o_input_pullup_en(o_input_pullup_en),
      .o_track_zero(o_track_zero), .o_disk_change(o_disk_change), .o_write_protect(o_write_protect),
      .o_sra_second_drive(o_sra_second_drive), .o_interface_mode(o_interface_mode),
      .o_enhanced_3mode(o_enhanced_3mode), .o_boot_drive(o_boot_drive),
      .o_tape_media_id(o_tape_media_id), .o_precomp_enable(o_precomp_enable),
      .o_rate_table_sel(o_rate_table_sel), .o_per_drive_type(o_per_drive_type),
      .o_drive_one_config(o_drive_one_config));

   floppy_drive_model floppy_drive_model_inst (.i_pol(ifc[BIT_POLARITY]), .i_pins(o_drive),
      .i_track_zero(st_tz), .i_disk_change(st_dc), .i_write_protect(st_wp),
      .o_track_zero_n(tz_n), .o_disk_change_n(dc_n), .o_write_protect_n(wp_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   // entered right after a rising edge; leaves one idle edge so psel never toggles twice at once
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      i_psel <= 1'h1;
      i_pwrite <= wr;
      i_paddr <= {2'h0, idx, 2'h0};
      i_pwdata <= {24'h0, d};
      @(posedge i_sys_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_pready !== 1'h1 && n < 50);
      if (n >= 50) fail_count++;
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      @(posedge i_sys_clk);
   endtask

   function automatic logic [3:0] exp_dma(input logic [7:0] c, input logic req);
      return (c[DMA_OFF_BIT] || !req) ? 4'h0 : 4'h1 << c[1:0];
   endfunction

   function automatic drive_pins_s exp_pins(input logic [7:0] f, b, r, input logic [1:0] ds, mo, dr,
                                            input logic wg, wd);
      logic sel;
      logic [1:0] den;
      drive_pins_s p;
      sel = (dr == 2'h0) || (dr == 2'h3);
      if (b[3:2] == DEN_FORCE_ONE) sel = 1'h1;
      else if (b[3:2] == DEN_FORCE_ZERO) sel = 1'h0;
      case (r[1:0])
         2'h1: den = {dr[0], dr[1]};
         2'h3: den = {dr[1], dr[0]};
         default: den = {dr[0], sel};
      endcase
      if (f[BIT_SWAP]) begin
         ds = {ds[0], ds[1]};
         mo = {mo[0], mo[1]};
      end
      p = {den, ds, mo, wg, wd};
      if (!f[BIT_POLARITY]) p = ~p;
      if (b[BIT_WRITE_INHIBIT]) begin
         p.write_gate = 1'h1;
         p.write_serial_out = 1'h1;
      end
      return p;
   endfunction

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(8 * 30000);
      fail_count++;
      conclude();
   end

   initial begin
      logic [31:0] rd;
      logic err;
      logic [7:0] v, bmw, rtp, dma, pdt, dcfg;
      logic sel;
      seed = 30;
      repeat (16) @(posedge i_sys_clk);
      i_resetn <= 1'h1;
      @(posedge i_sys_clk);
      for (int i = 0; i < REG_NUM; i++) begin
         apb(1'h0, REG_IDX[i], 8'h0, rd, err);
         chk("reset value", {24'h0, REG_RST[i]}, rd);
         v = $random(seed);
         apb(1'h1, REG_IDX[i], v, rd, err);
         chk("mapped error", 32'h0, {31'h0, err});
         apb(1'h0, REG_IDX[i], 8'h0, rd, err);
         chk("readback", {24'h0, v & REG_MASK[i]}, rd);
      end
      apb(1'h1, 8'hf3, 8'h5a, rd, err);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'h0, 8'hf3, 8'h0, rd, err);
      chk("unmapped data", 32'h0, rd);
      // every routing code, burst mode
      i_ctl_dma_request <= 1'h1;
      apb(1'h1, IDX_FLOPPY_INTERFACE_CONFIG, 8'h8c, rd, err);
      for (int c = 0; c < 8; c++) begin
         apb(1'h1, IDX_DMA_CHANNEL_SELECT, 8'(c), rd, err);
         repeat (2) @(posedge i_sys_clk);
         chk("dma route", {28'h0, exp_dma(8'(c), 1'h1)}, {28'h0, o_dma_request});
      end
      // one ack pulse: burst keeps the request, non-burst drops it briefly
      apb(1'h1, IDX_DMA_CHANNEL_SELECT, 8'h01, rd, err);
      for (int m = 0; m < 2; m++) begin
         apb(1'h1, IDX_FLOPPY_INTERFACE_CONFIG, m ? 8'h8e : 8'h8c, rd, err);
         repeat (2) @(posedge i_sys_clk);
         i_ctl_dma_ack <= 1'h1;
         @(posedge i_sys_clk);
         i_ctl_dma_ack <= 1'h0;
         repeat (2) begin
            @(posedge i_sys_clk);
            chk("dma after ack", m ? 32'h0 : 32'h2, {28'h0, o_dma_request});
         end
         repeat (2) @(posedge i_sys_clk);
         chk("dma resumed", 32'h2, {28'h0, o_dma_request});
      end
      for (int k = 0; k < 40; k++) begin
         ifc = $random(seed);
         bmw = $random(seed);
         rtp = $random(seed) & 8'h5b;
         dma = $random(seed) & 8'h07;
         pdt = $random(seed);
         dcfg = $random(seed);
         apb(1'h1, IDX_FLOPPY_INTERFACE_CONFIG, ifc, rd, err);
         apb(1'h1, IDX_BOOT_MEDIA_WRITE_CONFIG, bmw, rd, err);
         apb(1'h1, IDX_RATE_TABLE_PRECOMP_CONFIG, rtp, rd, err);
         apb(1'h1, IDX_DMA_CHANNEL_SELECT, dma, rd, err);
         apb(1'h1, IDX_PER_DRIVE_TYPE, pdt, rd, err);
         apb(1'h1, IDX_DRIVE_ONE_CONFIG, dcfg, rd, err);
         {i_ctl_dma_request, i_ctl_drive_sel, i_ctl_motor_on, i_ctl_write_gate, i_ctl_write_data,
            i_ctl_drate, st_tz, st_dc, st_wp} <= 12'($random(seed));
         repeat (6) @(posedge i_sys_clk);
         sel = |i_ctl_drive_sel;
         chk("dma", {28'h0, exp_dma(dma, i_ctl_dma_request)}, {28'h0, o_dma_request});
         chk("pins", {24'h0, exp_pins(ifc, bmw, rtp, i_ctl_drive_sel, i_ctl_motor_on, i_ctl_drate,
            i_ctl_write_gate, i_ctl_write_data)}, {24'h0, o_drive});
         chk("pullup", {31'h0, ~ifc[BIT_PULLUP_DIS]}, {31'h0, o_input_pullup_en});
         chk("second drive", {31'h0, ifc[3:2] == IF_PS2 && !ifc[5]}, {31'h0, o_sra_second_drive});
         chk("media id", {30'h0, bmw[5:4]}, {30'h0, o_tape_media_id});
         chk("track zero", {31'h0, sel ? st_tz : ifc[6]}, {31'h0, o_track_zero});
         chk("disk change", {31'h0, sel ? st_dc : ifc[6]}, {31'h0, o_disk_change});
         chk("protect", {31'h0, bmw[0] | (sel ? st_wp : ifc[6])}, {31'h0, o_write_protect});
         chk("precomp", {31'h0, ~rtp[6]}, {31'h0, o_precomp_enable});
         chk("rate table", {30'h0, rtp[4:3]}, {30'h0, o_rate_table_sel});
         chk("interface mode", {30'h0, ifc[3:2]}, {30'h0, o_interface_mode});
         chk("enhanced mode", {31'h0, ifc[0]}, {31'h0, o_enhanced_3mode});
         chk("boot drive", {30'h0, bmw[7:6]}, {30'h0, o_boot_drive});
         chk("drive types", {24'h0, pdt}, {24'h0, o_per_drive_type});
         chk("drive one", {24'h0, dcfg}, {24'h0, o_drive_one_config});
      end
      conclude();
   end
endmodule

// File: hw/floppy_cfg_pkg.sv
// floppy controller configuration register constants and carriers
// assumes an apb slave with 32-bit data; each register takes one word at four times its index
package floppy_cfg_pkg;
   localparam int REG_NUM = 6;
   localparam int ADDR_W = 12;
   // register slots
   localparam int SLOT_DMA = 0;
   localparam int SLOT_IFC = 1;
   localparam int SLOT_BMW = 2;
   localparam int SLOT_PDT = 3;
   localparam int SLOT_RTP = 4;
   localparam int SLOT_D1 = 5;
   // printed offsets are register indexes; byte address is four times the index
   localparam logic [7:0] IDX_DMA_CHANNEL_SELECT = 8'h74;
   localparam logic [7:0] IDX_FLOPPY_INTERFACE_CONFIG = 8'hf0;
   localparam logic [7:0] IDX_BOOT_MEDIA_WRITE_CONFIG = 8'hf1;
   localparam logic [7:0] IDX_PER_DRIVE_TYPE = 8'hf2;
   localparam logic [7:0] IDX_RATE_TABLE_PRECOMP_CONFIG = 8'hf4;
   localparam logic [7:0] IDX_DRIVE_ONE_CONFIG = 8'hf5;
   localparam logic [7:0] REG_IDX [REG_NUM] = '{IDX_DMA_CHANNEL_SELECT, IDX_FLOPPY_INTERFACE_CONFIG,
      IDX_BOOT_MEDIA_WRITE_CONFIG, IDX_PER_DRIVE_TYPE, IDX_RATE_TABLE_PRECOMP_CONFIG, IDX_DRIVE_ONE_CONFIG};
   localparam logic [7:0] REG_RST [REG_NUM] = '{8'h02, 8'h8e, 8'h00, 8'hff, 8'h00, 8'h00};
   // writable bits; the rest are reserved
   localparam logic [7:0] REG_MASK [REG_NUM] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'h5b, 8'hff};
   // dma channel select fields
   localparam int DMA_CH_LSB = 0;
   localparam int DMA_OFF_BIT = 2;
   // floppy interface config fields
   localparam int BIT_PULLUP_DIS = 7;
   localparam int BIT_POLARITY = 6;
   localparam int BIT_SECOND_DRIVE_N = 5;
   localparam int BIT_SWAP = 4;
   localparam int IFMODE_LSB = 2;
   localparam int BIT_DMA_NONBURST = 1;
   localparam int BIT_ENH_3MODE = 0;
   // boot media write config fields
   localparam int BOOT_LSB = 6;
   localparam int MEDIA_ID_LSB = 4;
   localparam int DENSITY_LSB = 2;
   localparam int BIT_WRITE_INHIBIT = 1;
   localparam int BIT_SW_WP = 0;
   // rate table precomp fields
   localparam int BIT_PRECOMP_DIS = 6;
   localparam int RATE_TABLE_LSB = 3;
   localparam int DRIVE_TYPE_LSB = 0;
   localparam logic [1:0] DEN_FORCE_ONE = 2'h2;
   localparam logic [1:0] DEN_FORCE_ZERO = 2'h3;
   localparam logic [3:0] DMA_CH0_ONEHOT = 4'h1;

   typedef enum logic [1:0] {IF_MODEL30, IF_PS2, IF_RESERVED, IF_AT} ifmode_e;
   typedef enum logic [1:0] {DT_SELDEN_A, DT_RATE_BOTH, DT_SELDEN_B, DT_RATE_SWAPPED} drive_type_e;

   // drive interface output pins, at pin level
   typedef struct packed {
      logic [1:0] density;
      logic [1:0] drive_sel;
      logic [1:0] motor_en;
      logic write_gate;
      logic write_serial_out;
   } drive_pins_s;
endpackage

// File: hw/floppy_ctrl_config_regs.sv
// floppy controller configuration registers and drive interface pin conditioning
// assumes controller core signals on i_sys_clk, drive pins asynchronous, apb master on i_sys_clk
`timescale 1ns/1ps
module floppy_ctrl_config_regs
   import floppy_cfg_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_ctl_dma_request,
   input wire logic i_ctl_dma_ack,
   input wire logic [1:0] i_ctl_drive_sel,
   input wire logic [1:0] i_ctl_motor_on,
   input wire logic i_ctl_write_gate,
   input wire logic i_ctl_write_data,
   input wire logic [1:0] i_ctl_drate,
   input wire logic i_track_zero_in_n,
   input wire logic i_disk_change_in_n,
   input wire logic i_write_protect_in_n,
   output logic [3:0] o_dma_request,
   output drive_pins_s o_drive,
   output logic o_input_pullup_en,
   output logic o_track_zero,
   output logic o_disk_change,
   output logic o_write_protect,
   output logic o_sra_second_drive,
   output logic [1:0] o_interface_mode,
   output logic o_enhanced_3mode,
   output logic [1:0] o_boot_drive,
   output logic [1:0] o_tape_media_id,
   output logic o_precomp_enable,
   output logic [1:0] o_rate_table_sel,
   output logic [7:0] o_per_drive_type,
   output logic [7:0] o_drive_one_config
);

////////////////////////////////////////////////////////////////////////////////
// apb decode

   logic [7:0] cfg [REG_NUM];
   logic [REG_NUM-1:0] hit;
   logic [7:0] rd_mux [REG_NUM+1];
   wire setup_phase = i_psel && !i_penable;
   wire access_done = i_psel && i_penable && o_pready;
   wire reg_wr = access_done && i_pwrite && !o_pslverr;
   wire mapped = |hit;

   genvar gi;
   generate
      for (gi = 0; gi < REG_NUM; gi++) begin : g_reg
         assign hit[gi] = (i_paddr == {2'h0, REG_IDX[gi], 2'h0});
         assign rd_mux[gi+1] = rd_mux[gi] | (hit[gi] ? (cfg[gi] & REG_MASK[gi]) : 8'h00);
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               cfg[gi] <= REG_RST[gi];
            end else if (reg_wr && hit[gi]) begin
               cfg[gi] <= i_pwdata[7:0] & REG_MASK[gi];
            end
         end
      end
   endgenerate
   assign rd_mux[0] = 8'h00;

   // one wait-free access phase: pready rises in the cycle after setup
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else begin
         o_pready <= setup_phase;
         o_pslverr <= setup_phase && !mapped;
         o_prdata <= (setup_phase && !i_pwrite) ? {24'h00_0000, rd_mux[REG_NUM]} : 32'h0000_0000;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// field views

   wire [1:0] dma_ch = cfg[SLOT_DMA][DMA_CH_LSB +: 2];
   wire dma_off = cfg[SLOT_DMA][DMA_OFF_BIT];
   wire pol = cfg[SLOT_IFC][BIT_POLARITY];
   wire swap = cfg[SLOT_IFC][BIT_SWAP];
   wire nonburst = cfg[SLOT_IFC][BIT_DMA_NONBURST];
   wire [1:0] den_code = cfg[SLOT_BMW][DENSITY_LSB +: 2];
   wire wr_inhibit = cfg[SLOT_BMW][BIT_WRITE_INHIBIT];
   wire sw_wp = cfg[SLOT_BMW][BIT_SW_WP];
   wire [1:0] dtype = cfg[SLOT_RTP][DRIVE_TYPE_LSB +: 2];
   wire ifmode_e ifmode = ifmode_e'(cfg[SLOT_IFC][IFMODE_LSB +: 2]);

////////////////////////////////////////////////////////////////////////////////
// dma request routing

   logic holdoff;
   // in non-burst mode, release for one extra cycle after each acknowledged transfer
   wire dma_req = i_ctl_dma_request && !dma_off && !holdoff && !(nonburst && i_ctl_dma_ack);
   wire [3:0] next_dma_request = dma_req ? 4'(DMA_CH0_ONEHOT << dma_ch) : 4'h0;

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         holdoff <= 1'b0;
         o_dma_request <= 4'h0;
      end else begin
         holdoff <= nonburst && i_ctl_dma_ack;
         o_dma_request <= next_dma_request;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// drive outputs

   // table a: density select is high for rate codes 00 and 11 unless forced; only DT_SELDEN_A and DT_SELDEN_B use it
   wire selden_raw = !(i_ctl_drate[1] ^ i_ctl_drate[0]);
   wire selden = (den_code == DEN_FORCE_ONE) ? 1'b1 : (den_code == DEN_FORCE_ZERO) ? 1'b0 : selden_raw;
   logic [1:0] den_logic;
   always_comb begin
      unique case (drive_type_e'(dtype))
         DT_RATE_BOTH: den_logic = {i_ctl_drate[0], i_ctl_drate[1]};
         DT_RATE_SWAPPED: den_logic = {i_ctl_drate[1], i_ctl_drate[0]};
         DT_SELDEN_A, DT_SELDEN_B: den_logic = {i_ctl_drate[0], selden};
      endcase
   end
   wire [1:0] sel_map = swap ? {i_ctl_drive_sel[0], i_ctl_drive_sel[1]} : i_ctl_drive_sel;
   wire [1:0] mot_map = swap ? {i_ctl_motor_on[0], i_ctl_motor_on[1]} : i_ctl_motor_on;
   wire [1:0] inv2 = {2{!pol}};
   drive_pins_s next_drive;
   assign next_drive.density = den_logic ^ inv2;
   assign next_drive.drive_sel = sel_map ^ inv2;
   assign next_drive.motor_en = mot_map ^ inv2;
   // inhibit wins over polarity: pins sit high, which keeps the drive from writing only while pol is low
   assign next_drive.write_gate = wr_inhibit ? 1'b1 : (i_ctl_write_gate ^ !pol);
   assign next_drive.write_serial_out = wr_inhibit ? 1'b1 : (i_ctl_write_data ^ !pol);

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_drive <= '1;
      end else begin
         o_drive <= next_drive;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// drive inputs: synchronise then apply polarity

   // only the last stage feeds logic; chain starts at the idle pin level so no false event follows reset
   logic [2:0] sync [SYNC_STAGES];
   wire [2:0] pins_sampled = sync[SYNC_STAGES-1];
   generate
      for (gi = 0; gi < SYNC_STAGES; gi++) begin : g_sync
         wire [2:0] stage_in;
         if (gi == 0) begin : g_first
            assign stage_in = {i_write_protect_in_n, i_disk_change_in_n, i_track_zero_in_n};
         end else begin : g_next
            assign stage_in = sync[gi-1];
         end
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               sync[gi] <= 3'h7;
            end else begin
               sync[gi] <= stage_in;
            end
         end
      end
   endgenerate
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_track_zero <= 1'b0;
         o_disk_change <= 1'b0;
         o_write_protect <= 1'b0;
      end else begin
         o_track_zero <= !(pins_sampled[0] ^ pol);
         o_disk_change <= !(pins_sampled[1] ^ pol);
         o_write_protect <= sw_wp || !(pins_sampled[2] ^ pol);
      end
   end

////////////////////////////////////////////////////////////////////////////////
// status and configuration views for the controller core

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_input_pullup_en <= 1'b0;
         o_sra_second_drive <= 1'b0;
         o_interface_mode <= 2'h0;
         o_enhanced_3mode <= 1'b0;
         o_boot_drive <= 2'h0;
         o_tape_media_id <= 2'h0;
         o_precomp_enable <= 1'b0;
         o_rate_table_sel <= 2'h0;
         o_per_drive_type <= 8'h00;
         o_drive_one_config <= 8'h00;
      end else begin
         o_input_pullup_en <= !cfg[SLOT_IFC][BIT_PULLUP_DIS];
         o_sra_second_drive <= (ifmode == IF_PS2) && !cfg[SLOT_IFC][BIT_SECOND_DRIVE_N];
         o_interface_mode <= cfg[SLOT_IFC][IFMODE_LSB +: 2];
         o_enhanced_3mode <= cfg[SLOT_IFC][BIT_ENH_3MODE];
         o_boot_drive <= cfg[SLOT_BMW][BOOT_LSB +: 2];
         o_tape_media_id <= cfg[SLOT_BMW][MEDIA_ID_LSB +: 2];
         o_precomp_enable <= !cfg[SLOT_RTP][BIT_PRECOMP_DIS];
         o_rate_table_sel <= cfg[SLOT_RTP][RATE_TABLE_LSB +: 2];
         o_per_drive_type <= cfg[SLOT_PDT];
         o_drive_one_config <= cfg[SLOT_D1];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   property p_dma_route;
      !reg_wr && !nonburst && !holdoff && !dma_off && i_ctl_dma_request
         |=> o_dma_request == 4'(DMA_CH0_ONEHOT << dma_ch);
   endproperty
   a_dma_route: assert property (p_dma_route) else $error("dma request on wrong channel");

   property p_dma_off;
      dma_off |=> o_dma_request == 4'h0;
   endproperty
   a_dma_off: assert property (p_dma_off) else $error("dma request while disabled");

   property p_pullup;
      $rose(cfg[SLOT_IFC][BIT_PULLUP_DIS]) |=> !o_input_pullup_en;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-ups left on after disable");

   property p_track_polarity;
      (!reg_wr && $stable(i_track_zero_in_n))[*4] |=> o_track_zero == !($past(i_track_zero_in_n) ^ pol);
   endproperty
   a_track_polarity: assert property (p_track_polarity) else $error("track zero polarity wrong");

   property p_second_drive;
      !reg_wr |=> o_sra_second_drive == (ifmode == IF_PS2 && !cfg[SLOT_IFC][BIT_SECOND_DRIVE_N]);
   endproperty
   a_second_drive: assert property (p_second_drive) else $error("second drive status wrong");

   property p_swap;
      !reg_wr && swap |=> o_drive.drive_sel == ({$past(i_ctl_drive_sel[0]), $past(i_ctl_drive_sel[1])} ^ inv2);
   endproperty
   a_swap: assert property (p_swap) else $error("drive select not swapped");

   property p_nonburst;
      nonburst && !reg_wr && i_ctl_dma_ack |=> (o_dma_request == 4'h0)[*2];
   endproperty
   a_nonburst: assert property (p_nonburst) else $error("request not released after transfer");

   property p_media_id;
      !reg_wr |=> o_tape_media_id == cfg[SLOT_BMW][MEDIA_ID_LSB +: 2];
   endproperty
   a_media_id: assert property (p_media_id) else $error("media id not reflected");

   property p_density_force;
      !reg_wr && den_code == DEN_FORCE_ZERO && dtype == DT_SELDEN_A |=> o_drive.density[0] == !pol;
   endproperty
   a_density_force: assert property (p_density_force) else $error("density not forced low");

   property p_write_inhibit;
      wr_inhibit && !reg_wr |=> o_drive.write_gate && o_drive.write_serial_out;
   endproperty
   a_write_inhibit: assert property (p_write_inhibit) else $error("write pins not held high");

   property p_sw_wp;
      sw_wp && !reg_wr |=> o_write_protect;
   endproperty
   a_sw_wp: assert property (p_sw_wp) else $error("software write protect ignored");

   property p_precomp;
      !reg_wr |=> o_precomp_enable != cfg[SLOT_RTP][BIT_PRECOMP_DIS];
   endproperty
   a_precomp: assert property (p_precomp) else $error("precomp enable inverted");

   property p_rate_table;
      !reg_wr |=> o_rate_table_sel == cfg[SLOT_RTP][RATE_TABLE_LSB +: 2];
   endproperty
   a_rate_table: assert property (p_rate_table) else $error("rate table select stale");

   property p_drive_type;
      !reg_wr && dtype == DT_RATE_SWAPPED |=> o_drive.density == ($past(i_ctl_drate) ^ inv2);
   endproperty
   a_drive_type: assert property (p_drive_type) else $error("density sources wrong");

   property p_reserved;
      setup_phase && !i_pwrite && hit[SLOT_DMA] |=> o_prdata[31:3] == 29'h0 ##1 cfg[SLOT_DMA][7:3] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_unmapped;
      setup_phase && !mapped |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

   property p_unmapped_write;
      access_done && i_pwrite && o_pslverr |=> $stable(cfg[SLOT_PDT]) && $stable(cfg[SLOT_D1]);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("refused write changed a register");

   property p_pullup_on;
      $fell(cfg[SLOT_IFC][BIT_PULLUP_DIS]) |=> o_input_pullup_en;
   endproperty
   a_pullup_on: assert property (p_pullup_on) else $error("pull-ups not enabled");

   property p_no_swap;
      !reg_wr && !swap |=> o_drive.drive_sel == ($past(i_ctl_drive_sel) ^ inv2);
   endproperty
   a_no_swap: assert property (p_no_swap) else $error("drive select not direct");

   property p_motor_swap;
      !reg_wr && swap |=> o_drive.motor_en == ({$past(i_ctl_motor_on[0]), $past(i_ctl_motor_on[1])} ^ inv2);
   endproperty
   a_motor_swap: assert property (p_motor_swap) else $error("motor select not swapped");

   property p_write_pass;
      !wr_inhibit && !reg_wr |=> o_drive.write_gate == ($past(i_ctl_write_gate) ^ !pol)
         && o_drive.write_serial_out == ($past(i_ctl_write_data) ^ !pol);
   endproperty
   a_write_pass: assert property (p_write_pass) else $error("write pins blocked");

   property p_density_one;
      !reg_wr && den_code == DEN_FORCE_ONE && dtype == DT_SELDEN_B |=> o_drive.density[0] == pol;
   endproperty
   a_density_one: assert property (p_density_one) else $error("density not forced high");

   property p_rate_both;
      !reg_wr && dtype == DT_RATE_BOTH
         |=> o_drive.density == ({$past(i_ctl_drate[0]), $past(i_ctl_drate[1])} ^ inv2);
   endproperty
   a_rate_both: assert property (p_rate_both) else $error("rate density sources wrong");

   property p_burst_keep;
      !nonburst && !holdoff && !dma_off && !reg_wr && i_ctl_dma_request && i_ctl_dma_ack
         |=> o_dma_request != 4'h0;
   endproperty
   a_burst_keep: assert property (p_burst_keep) else $error("burst request dropped on ack");

endmodule
